// ==== bench/bpu_cpu_model.sv ====
// CPU core model on the far side of the break point unit.
// Assumes one fetch and boundary per cycle while run is high.
module bpu_cpu_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic break_mode_i,
    output logic [15:0] pc_o,
    output logic fetch_o,
    output logic rti_o,
    output logic [7:0] opcode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    // Bit 7 kept low so a forced opcode is never mistaken for a fetched one
    assign opcode_o = {1'b0, pc_o[6:0]};
    assign fetch_o = run_i & ~rst_i;
    assign rti_o = run_i & break_mode_i & (cnt_r == 2'h2);
    // Routine length counted only while running, so the bench can park inside break
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_o <= 16'h0000;
            cnt_r <= 2'h0;
        end
        else if (run_i)
        begin
            pc_o <= pc_o + 16'h0001;
            cnt_r <= break_mode_i ? cnt_r + {1'b0, cnt_r != 2'h3} : 2'h0;
        end
    end
endmodule // bpu_cpu_model

// ==== bench/break_point_unit_tb.sv ====
// Self-checking bench for the break point unit, with the CPU core model.
// Assumes registered Wishbone ack and the register map of the package.
module break_point_unit_tb import bpu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, run = 0, lp = 0, mon = 0;
    logic ack, breakpoint_signal, break_unit, permit, hold, irq, fetch, return_from_interrupt, seen;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h0, rd, q;
    logic [31:0] seed = 32'h00011259;
    logic [7:0] op, op_out, prev_op;
    logic [15:0] pc, vec, prev, tgt;
    int errors = 0, total_checks = 0;
    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;
    bpu_break_point_unit i_bpu_break_point_unit (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .cpu_pc_i(pc), .cpu_fetch_i(fetch),
        .cpu_boundary_i(fetch), .cpu_rti_i(return_from_interrupt), .cpu_opcode_i(op), .low_power_i(lp),
        .monitor_mode_i(mon), .cpu_opcode_o(op_out), .break_vector_o(vec),
        .breakpoint_signal_o(breakpoint_signal), .break_mode_o(break_unit), .flag_clear_permit_o(permit),
        .watchdog_hold_o(hold), .irq_o(irq));
    bpu_cpu_model i_bpu_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
        .break_mode_i(break_unit), .pc_o(pc), .fetch_o(fetch), .rti_o(return_from_interrupt), .opcode_o(op));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bust();
        errors++;
        tally_and_finish();
    endtask
    // Classic single cycle; held until ack is seen high at a rising edge
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) bust();
        rd = q;
        cyc <= 0;
    endtask
    // Bounded wait for a break level, remembering the previous cycle's PC
    task automatic wait_brk(input logic v);
        int n;
        for (n = 0; n < 50 && break_unit !== v; n++)
        begin
            prev = pc;
            prev_op = op_out;
            @(negedge clk_i);
        end
        if (break_unit !== v) bust();
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        // Reset values, the last offset unmapped
        for (int i = 0; i < 6; i++)
        begin
            wb(0, 5'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        chk(permit, 1'b1);
        wb(1, BPU_OFS_IRQ_MASK, 32'h1);
        // Address break in normal and monitor mode
        for (int m = 0; m < 2; m++)
        begin
            mon <= m[0];
            tgt = pc + 16'd4 + 16'(rnd() % 8);
            wb(1, 5'(BPU_OFS_ADDR), {16'h0, tgt});
            wb(1, 5'(BPU_OFS_CTRL), 32'h80);
            run <= 1;
            wait_brk(1);
            chk(prev, tgt);
            chk(prev_op, BPU_SOFT_INT_OPCODE);
            chk(op_out, op);
            chk(vec, m ? BPU_VEC_MONITOR : BPU_VEC_NORMAL);
            chk(hold, 1'b1);
            chk(irq, 1'b1);
            @(posedge clk_i);
            run <= 0;
            chk(permit, 1'b0);
            wb(1, 5'(BPU_OFS_FLAG), 32'h80);
            chk(permit, 1'b1);
            wb(1, 5'(BPU_OFS_FLAG), 32'h0);
            chk(permit, 1'b0);
            wb(0, 5'(BPU_OFS_IRQ_STAT), 32'h0);
            chk(rd, 32'h1);
            wb(1, BPU_OFS_IRQ_MASK, 32'h0);
            @(negedge clk_i);
            chk(irq, 1'b0);
            wb(1, BPU_OFS_IRQ_MASK, 32'h1);
            run <= 1;
            wait_brk(0);
            chk(permit, 1'b1);
            chk(hold, 1'b0);
            chk(op_out, op);
            wb(0, 5'(BPU_OFS_IRQ_STAT), 32'h0);
            chk(rd, 32'h3);
            wb(1, 5'(BPU_OFS_IRQ_STAT), 32'h3);
            @(negedge clk_i);
            chk(irq, 1'b0);
            wb(1, 5'(BPU_OFS_CTRL), 32'h0);
            run <= 0;
        end
        // Software break with the PC parked away from the address
        wb(1, 5'(BPU_OFS_ADDR), {16'h0, pc - 16'd1});
        wb(1, 5'(BPU_OFS_CTRL), 32'hC0);
        @(negedge clk_i);
        chk(breakpoint_signal, 1'b1);
        wb(0, 5'(BPU_OFS_CTRL), 32'h0);
        chk(rd, 32'hC0);
        run <= 1;
        wait_brk(1);
        chk(prev_op, BPU_SOFT_INT_OPCODE);
        wait_brk(0);
        wb(1, 5'(BPU_OFS_CTRL), 32'h0);
        // Low power: fetches still reach the address but must not break
        run <= 0;
        lp <= 1;
        wb(1, 5'(BPU_OFS_ADDR), {16'h0, pc + 16'd4});
        wb(1, 5'(BPU_OFS_CTRL), 32'h80);
        run <= 1;
        seen = 0;
        repeat (12)
        begin
            @(negedge clk_i);
            seen |= break_unit | breakpoint_signal;
        end
        chk(seen, 1'b0);
        tally_and_finish();
    end
endmodule // break_point_unit_tb

// ==== rtl/bpu_break_point_unit.sv ====
// Break point unit with the break-mode handling of the system integration logic.
// Assumes the CPU core reports fetches, boundaries and interrupt returns as one-cycle pulses
// on the bus clock, and that peripherals honour the flag-clear permit output.
// Summary of operation
// - PC equal to break address off a boundary raises the breakpoint signal toward integration logic; on a boundary it enters break at once.
// - On breakpoint, the fetched instruction is replaced by the software interrupt opcode.
// - Break vector is FFFC normally, FEFC in monitor mode.
// - Writing one to the break-active bit starts a break like a match.
// - Only CPU program counter addresses are compared for address breaks.
// - Return-from-interrupt inside the break routine ends break mode.
// - In break, flags clear only when the clear-enable bit is one.
// - Flags cleared during break stay cleared afterwards.
// - Two-step clears stay blocked in break; second step after break clears normally.
// - Watchdog is held off while a break is in progress.
// - In wait or stop no address match break is produced.
module bpu_break_point_unit
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU core side
    input wire logic [15:0] cpu_pc_i,
    input wire logic cpu_fetch_i,
    input wire logic cpu_boundary_i,
    input wire logic cpu_rti_i,
    input wire logic [7:0] cpu_opcode_i,
    input wire logic low_power_i,
    input wire logic monitor_mode_i,
    output logic [7:0] cpu_opcode_o,
    output logic [15:0] break_vector_o,
    output logic breakpoint_signal_o,
    output logic break_mode_o,
    output logic flag_clear_permit_o,
    output logic watchdog_hold_o,
    output logic irq_o
);
    import bpu_pkg::*;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] ctrl;
        logic [7:0] flag;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic pending;
        logic in_break;
        logic inject;
        logic ack;
        logic [31:0] rdata;
    } bpu_state_t;

    bpu_state_t st_r;
    bpu_state_t st_nxt;
    logic bus_req;
    logic bus_wr;
    logic addr_hit;
    logic sw_start;
    logic entry_ev;
    logic exit_ev;
    logic swap_now;

    // Register read mux; unmapped offsets read as zero
    function automatic logic [31:0] bpu_read(input bpu_state_t s, input logic [4:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            {1'b0, BPU_OFS_ADDR}: d = {16'h0000, s.addr};
            {1'b0, BPU_OFS_CTRL}: d = {24'h000000, s.ctrl[7], s.in_break | s.pending, 6'h00};
            {1'b0, BPU_OFS_FLAG}: d = {24'h000000, s.flag};
            {1'b0, BPU_OFS_IRQ_STAT}: d = {30'h0, s.irq_stat};
            BPU_OFS_IRQ_MASK: d = {30'h0, s.irq_mask};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Bus strobe qualification, ack drops one cycle after it was given
    assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign bus_wr = bus_req & wb_we_i;

    // Address compare against the program counter only, gated by enable and low power
    // PC compare source
    // No match in wait or stop
    assign addr_hit = st_r.ctrl[BPU_CTRL_ENABLE] & cpu_fetch_i & ~low_power_i
                    & (cpu_pc_i == st_r.addr);

    // Software start by writing one to the break-active bit
    // Software break start
    assign sw_start = bus_wr & (wb_adr_i == {1'b0, BPU_OFS_CTRL}) & wb_sel_i[0]
                    & wb_dat_i[BPU_CTRL_ACTIVE];

    // Entry happens when a pending or same-cycle request meets an instruction boundary
    // Take at boundary
    assign entry_ev = (st_r.pending | addr_hit | sw_start) & cpu_boundary_i & ~st_r.in_break;
    assign exit_ev = st_r.in_break & cpu_rti_i & ~st_r.inject;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = bus_req;
        st_nxt.rdata = bus_req ? bpu_read(st_r, wb_adr_i) : st_r.rdata;
        // Register writes on the lowest byte lanes
        if (bus_wr)
        begin
            unique case (wb_adr_i)
                {1'b0, BPU_OFS_ADDR}:
                begin
                    if (wb_sel_i[0])
                        st_nxt.addr[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        st_nxt.addr[15:8] = wb_dat_i[15:8];
                end
                {1'b0, BPU_OFS_CTRL}:
                begin
                    if (wb_sel_i[0])
                        st_nxt.ctrl[BPU_CTRL_ENABLE] = wb_dat_i[BPU_CTRL_ENABLE];
                end
                {1'b0, BPU_OFS_FLAG}:
                begin
                    if (wb_sel_i[0])
                        st_nxt.flag[BPU_FLAG_CLEAR_EN] = wb_dat_i[BPU_FLAG_CLEAR_EN];
                end
                {1'b0, BPU_OFS_IRQ_STAT}:
                begin
                    if (wb_sel_i[0])
                        st_nxt.irq_stat = st_r.irq_stat & ~wb_dat_i[1:0];
                end
                BPU_OFS_IRQ_MASK:
                begin
                    if (wb_sel_i[0])
                        st_nxt.irq_mask = wb_dat_i[1:0];
                end
                default:
                begin
                end
            endcase
        end
        // Latch requests that arrive off a boundary so none is lost
        // Match raises breakpoint
        if ((addr_hit | sw_start) & ~st_r.in_break)
            st_nxt.pending = 1'b1;
        if (entry_ev)
        begin
            st_nxt.pending = 1'b0;
            st_nxt.in_break = 1'b1;
            // Arm the swap only when the entry cycle carried no opcode fetch
            st_nxt.inject = ~cpu_fetch_i;
        end
        // Injection lasts for one opcode fetch after entry
        if (st_r.inject & cpu_fetch_i)
            st_nxt.inject = 1'b0;
        if (exit_ev)
            st_nxt.in_break = 1'b0;
        // Events set sticky bits; set wins over a same-cycle clear
        if (entry_ev)
            st_nxt.irq_stat[BPU_IRQ_ENTRY] = 1'b1;
        if (exit_ev)
            st_nxt.irq_stat[BPU_IRQ_EXIT] = 1'b1;
        if (rst_i)
        begin
            st_nxt.addr = BPU_ADDR_RST;
            st_nxt.ctrl = BPU_CTRL_RST;
            st_nxt.flag = BPU_FLAG_RST;
            st_nxt.irq_stat = BPU_IRQ_RST;
            st_nxt.irq_mask = BPU_IRQ_RST;
            st_nxt.pending = 1'b0;
            st_nxt.in_break = 1'b0;
            st_nxt.inject = 1'b0;
            st_nxt.ack = 1'b0;
            st_nxt.rdata = 32'h0000_0000;
        end
    end

    // Single state register
    always_ff @(posedge clk_i)
    begin
        st_r <= st_nxt;
    end

    // Bus outputs
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;

    // Breakpoint request shown from match until break is entered
    assign breakpoint_signal_o = st_r.pending;
    assign break_mode_o = st_r.in_break;

    // Force software interrupt opcode
    // The opcode fetched in the entry cycle is the one at the matching address, so it is
    // swapped at once; the armed swap only covers an entry taken without a fetch.
    assign swap_now = st_r.inject | (entry_ev & cpu_fetch_i);
    assign cpu_opcode_o = swap_now ? BPU_SOFT_INT_OPCODE : cpu_opcode_i;

    assign break_vector_o = monitor_mode_i ? BPU_VEC_MONITOR : BPU_VEC_NORMAL;

    // Peripherals clear flags only with this permit; cleared flags are never restored, and a
    // second clear step is refused during break while the clear-enable bit is zero, since the permit is gated by break state.
    // Clear-enable gating
    assign flag_clear_permit_o = ~st_r.in_break | st_r.flag[BPU_FLAG_CLEAR_EN];

    assign watchdog_hold_o = st_r.in_break;

    // Level interrupt from unmasked sticky bits
    assign irq_o = |(st_r.irq_stat & st_r.irq_mask);

    // Assertions
    sequence s_hit_boundary;
        addr_hit && cpu_boundary_i && !st_r.in_break;
    endsequence

    a_match_enters_break: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hit_boundary |=> break_mode_o)
        else $error("address match did not enter break");

    a_opcode_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hit_boundary |-> cpu_opcode_o == BPU_SOFT_INT_OPCODE)
        else $error("software interrupt opcode not forced");

    a_vector_select: assert property (@(posedge clk_i) disable iff (rst_i)
        break_vector_o == (monitor_mode_i ? 16'hFEFC : 16'hFFFC))
        else $error("wrong break vector");

    a_sw_start_break: assert property (@(posedge clk_i) disable iff (rst_i)
        sw_start && !st_r.in_break |=> breakpoint_signal_o || break_mode_o)
        else $error("software start did not request break");

    a_rti_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        break_mode_o && cpu_rti_i && !st_r.inject |=> !break_mode_o)
        else $error("return from interrupt did not end break");

    a_clear_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
        break_mode_o && !st_r.flag[BPU_FLAG_CLEAR_EN] |-> !flag_clear_permit_o)
        else $error("flag clear allowed in break");

    a_watchdog_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(break_mode_o) |-> watchdog_hold_o)
        else $error("watchdog not held in break");

    a_low_power_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power_i && !sw_start && !breakpoint_signal_o |=> !breakpoint_signal_o)
        else $error("address break raised in low power");

    a_pc_only: assert property (@(posedge clk_i) disable iff (rst_i)
        addr_hit |-> cpu_pc_i == st_r.addr && cpu_fetch_i)
        else $error("break compare used non-PC address");

    a_boundary_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(break_mode_o) |-> $past(cpu_boundary_i))
        else $error("break entered off an instruction boundary");

    // Bus handshake: one registered ack per request, never two in a row
    a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a bus request");

    // A latched request that meets an instruction boundary
    sequence s_pending_boundary;
        breakpoint_signal_o && cpu_boundary_i;
    endsequence

    // A software start written while no boundary is present
    sequence s_sw_off_boundary;
        sw_start && !st_r.in_break && !cpu_boundary_i;
    endsequence

    // Requests wait for a boundary and are never dropped on the way
    a_request_held: assert property (@(posedge clk_i) disable iff (rst_i)
        breakpoint_signal_o && !cpu_boundary_i |=> breakpoint_signal_o)
        else $error("break request lost before a boundary");

    a_pending_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pending_boundary |=> break_mode_o && !breakpoint_signal_o)
        else $error("pending request not taken at the boundary");

    a_sw_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sw_off_boundary |=> breakpoint_signal_o)
        else $error("software start not latched");

    a_entry_on_boundary: assert property (@(posedge clk_i) disable iff (rst_i)
        !break_mode_o && !cpu_boundary_i |=> !break_mode_o)
        else $error("break entered without a boundary");

    a_request_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        break_mode_o |-> !breakpoint_signal_o)
        else $error("break request shown while in break");

    // Outside the swap the fetched opcode must reach the core untouched
    a_opcode_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_r.inject && !entry_ev |-> cpu_opcode_o == cpu_opcode_i)
        else $error("fetched opcode altered outside a break entry");

    // Break mode, flag permit and watchdog hold
    a_break_held: assert property (@(posedge clk_i) disable iff (rst_i)
        break_mode_o && !cpu_rti_i |=> break_mode_o)
        else $error("break mode ended without a return");

    a_permit_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
        break_mode_o && st_r.flag[BPU_FLAG_CLEAR_EN] |-> flag_clear_permit_o)
        else $error("flag clear refused although enabled");

    a_permit_after_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(break_mode_o) |-> flag_clear_permit_o)
        else $error("flag clear refused after break");

    a_permit_outside: assert property (@(posedge clk_i) disable iff (rst_i)
        !break_mode_o |-> flag_clear_permit_o)
        else $error("flag clear refused outside break");

    a_watchdog_free: assert property (@(posedge clk_i) disable iff (rst_i)
        !break_mode_o |-> !watchdog_hold_o)
        else $error("watchdog held outside break");

    // Low power and interrupt status
    a_idle_no_match: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power_i |-> !addr_hit)
        else $error("address compare active in low power");

    a_entry_status: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(break_mode_o) |-> st_r.irq_stat[BPU_IRQ_ENTRY])
        else $error("entry status bit not set");

    a_exit_status: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(break_mode_o) |-> st_r.irq_stat[BPU_IRQ_EXIT])
        else $error("exit status bit not set");

endmodule // bpu_break_point_unit

// ==== rtl/bpu_pkg.sv ====
// Constants shared by the break point unit: register map, field positions, vectors.
// Assumes a 32-bit classic Wishbone bus with byte addresses and registers of up to 16 bits in the low lanes.
package bpu_pkg;
    // Register byte offsets
    localparam logic [3:0] BPU_OFS_ADDR = 4'h0;
    localparam logic [3:0] BPU_OFS_CTRL = 4'h4;
    localparam logic [3:0] BPU_OFS_FLAG = 4'h8;
    localparam logic [3:0] BPU_OFS_IRQ_STAT = 4'hC;
    localparam logic [4:0] BPU_OFS_IRQ_MASK = 5'h10;
    // Control register fields
    localparam int BPU_CTRL_ENABLE = 7;
    localparam int BPU_CTRL_ACTIVE = 6;
    // Break flag control fields
    localparam int BPU_FLAG_CLEAR_EN = 7;
    // Interrupt status fields
    localparam int BPU_IRQ_ENTRY = 0;
    localparam int BPU_IRQ_EXIT = 1;
    // Reset values
    localparam logic [15:0] BPU_ADDR_RST = 16'h0000;
    localparam logic [7:0] BPU_CTRL_RST = 8'h00;
    localparam logic [7:0] BPU_FLAG_RST = 8'h00;
    localparam logic [1:0] BPU_IRQ_RST = 2'h0;
    // Break vectors, normal and monitor mode
    localparam logic [15:0] BPU_VEC_NORMAL = 16'hFFFC;
    localparam logic [15:0] BPU_VEC_MONITOR = 16'hFEFC;
    // Forced software interrupt opcode
    localparam logic [7:0] BPU_SOFT_INT_OPCODE = 8'h83;
endpackage : bpu_pkg
